// ===== bench/analog_debug_regs_props.sv
// concurrent checks on the ports of the analog debug register bank
`timescale 1ns/100ps
module analog_debug_regs_props
(
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [23:0] DAC_LEFT_IN,
    input wire logic [23:0] DAC_RIGHT_IN,
    input wire logic [23:0] DAC_RIGHT_OUT,
    input wire logic        DAC_LEFT_COPY_TO_RIGHT,
    input wire logic        PLL_OSCILLATOR_RETUNE,
    input wire logic [2:0]  RIGHT_SHORT_TRIP_LEVEL,
    input wire logic [7:0]  RIGHT_SHORT_TRIP_MA
);
    logic unm;
    logic acc;
    assign unm = (PADDR[11:2] != 10'h03A) && (PADDR[11:2] != 10'h03C);
    assign acc = PSEL && PENABLE;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    a_ready_high: assert property (PREADY) else $error("ready low");
    a_err_flag: assert property (acc |-> PSLVERR == unm) else $error("error flag wrong");
    a_read_unmapped: assert property (acc && !PWRITE && unm |-> PRDATA == 32'h0000_0000) else $error("unmapped read");
    a_copy_right: assert property (DAC_LEFT_COPY_TO_RIGHT |=> DAC_RIGHT_OUT == $past(DAC_LEFT_IN)) else $error("no copy");
    a_pass_right: assert property (!DAC_LEFT_COPY_TO_RIGHT |=> DAC_RIGHT_OUT == $past(DAC_RIGHT_IN)) else $error("bad pass");
    a_retune_width: assert property ($rose(PLL_OSCILLATOR_RETUNE) |=> !PLL_OSCILLATOR_RETUNE) else $error("pulse wide");
    a_trip_decode: assert property (RIGHT_SHORT_TRIP_MA == (RIGHT_SHORT_TRIP_LEVEL[2] ? 8'h19 * {5'h00, RIGHT_SHORT_TRIP_LEVEL} + 8'h19
        : 8'h64 - 8'h19 * {5'h00, RIGHT_SHORT_TRIP_LEVEL})) else $error("trip decode");
    a_trip_write: assert property (acc && PWRITE && PADDR[11:2] == 10'h03C && PSTRB[1]
        |=> RIGHT_SHORT_TRIP_LEVEL == $past(PWDATA[14:12])) else $error("trip write");
    a_trip_read: assert property (acc && !PWRITE && PADDR[11:2] == 10'h03C
        |-> PRDATA[15:0] == {1'b0, RIGHT_SHORT_TRIP_LEVEL, 12'h000}) else $error("trip read");
endmodule : analog_debug_regs_props

bind analog_debug_regs analog_debug_regs_props u_props (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DAC_LEFT_IN(DAC_LEFT_IN), .DAC_RIGHT_IN(DAC_RIGHT_IN), .DAC_RIGHT_OUT(DAC_RIGHT_OUT),
    .DAC_LEFT_COPY_TO_RIGHT(DAC_LEFT_COPY_TO_RIGHT), .PLL_OSCILLATOR_RETUNE(PLL_OSCILLATOR_RETUNE),
    .RIGHT_SHORT_TRIP_LEVEL(RIGHT_SHORT_TRIP_LEVEL), .RIGHT_SHORT_TRIP_MA(RIGHT_SHORT_TRIP_MA));

// ===== bench/tb.sv
// self-checking bench for the analog debug register bank
`timescale 1ns/100ps
module tb import anadbg_pkg::*;;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'h0;
    logic [23:0] dl = 24'h00_0000;
    logic [23:0] dr = 24'h00_0000;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [23:0] lo;
    wire  [23:0] ro;
    wire  [14:0] ctl;
    wire         retune;
    wire  [2:0]  trip;
    wire  [7:0]  ma;
    reg_word_t   rd;
    logic        er;
    int          fails = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n;
    logic [7:0]  tbl [8] = '{8'h64, 8'h4B, 8'h32, 8'h19, 8'h7D, 8'h96, 8'hAF, 8'hC8};
    assign ctl[11] = 1'b0;
    always #5 clk = ~clk;
    analog_debug_regs DUT (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DAC_LEFT_IN(dl),
        .DAC_RIGHT_IN(dr), .DAC_LEFT_OUT(lo), .DAC_RIGHT_OUT(ro), .LINE_OUT_SUPPLY_SELECT(ctl[14]),
        .SPARE_TO_ANALOG(ctl[13]), .DAC_LEFT_COPY_TO_RIGHT(ctl[12]), .PLL_OSCILLATOR_RETUNE(retune),
        .LINE_OUT_REFERENCE_TIE(ctl[10]), .DAC_SAMPLE_EDGE_FLIP(ctl[9]), .DAC_TRANSFER_EDGE_FLIP(ctl[8]),
        .DAC_ZERO_RETURN_EXTEND(ctl[7]), .DAC_AMP_CURRENT_DOUBLE(ctl[6]), .DAC_ZERO_RETURN_DISABLE(ctl[5]),
        .DAC_AMP_CLASS_A_FORCE(ctl[4]), .ADC_SAMPLE_EDGE_FLIP(ctl[3]), .ADC_TRANSFER_EDGE_FLIP(ctl[2]),
        .ADC_BIAS_REDUCE(ctl[1]), .ADC_DITHER_DISABLE(ctl[0]), .RIGHT_SHORT_TRIP_LEVEL(trip), .RIGHT_SHORT_TRIP_MA(ma));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one transfer; register index 0x03A at byte 0x0E8, index 0x03C at byte 0x0F0
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = wr ? 16'h0000 : prdata[15:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic pulses;
        n = 0;
        repeat (6)
        begin
            @(posedge clk);
            #1;
            if (retune === 1'b1)
                n++;
        end
    endtask : pulses
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        apb(1'b0, 12'h0E8, 32'h0000_0000, 4'h0);
        chk(rd, 16'h0000);
        chk(ctl, 15'h0000);
        chk(ma, 8'h64);
    endtask : t_reset
    task automatic t_fields;
        for (int i = 0; i < 15; i++)
        begin
            if (i == 11)
                continue;
            apb(1'b1, 12'h0E8, 32'h0000_0001 << i, 4'h3);
            chk(ctl, 15'h0001 << i);
            apb(1'b0, 12'h0EA, 32'h0000_0000, 4'h0);
            chk(rd, 16'h0001 << i);
        end
        apb(1'b1, 12'h0E8, 32'h0000_FFFF, 4'h3);
        apb(1'b0, 12'h0E8, 32'h0000_0000, 4'h0);
        chk(rd, 16'h7FFF);
        apb(1'b1, 12'h0E8, 32'h0000_0000, 4'h3);
        pulses();
        chk(n, 1);
        apb(1'b1, 12'h0E8, 32'h0000_0000, 4'h3);
        pulses();
        chk(n, 0);
        apb(1'b1, 12'h0E8, 32'h0000_FFFF, 4'h0);
        chk(ctl, 15'h0000);
    endtask : t_fields
    task automatic t_mono;
        apb(1'b1, 12'h0E8, 32'h0000_1000, 4'h3);
        dl <= 24'hA5_1234;
        dr <= 24'h5A_9876;
        @(posedge clk);
        @(posedge clk);
        #1;
        chk(ro, 24'hA5_1234);
        chk(lo, 24'hA5_1234);
        apb(1'b1, 12'h0E8, 32'h0000_0000, 4'h3);
        @(posedge clk);
        #1;
        chk(ro, 24'h5A_9876);
    endtask : t_mono
    task automatic t_trip;
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, 12'h0F0, 32'h0000_8FFF | (c << 12), 4'h3);
            chk(trip, c);
            chk(ma, tbl[c]);
            apb(1'b0, 12'h0F0, 32'h0000_0000, 4'h0);
            chk(rd, c << 12);
        end
    endtask : t_trip
    task automatic t_unmapped;
        apb(1'b1, 12'h100, 32'hFFFF_FFFF, 4'hF);
        chk(er, 1'b1);
        apb(1'b0, 12'h100, 32'h0000_0000, 4'h0);
        chk(rd, 16'h0000);
        chk(ctl, 15'h0000);
    endtask : t_unmapped
    // limit well above the fewer than two hundred cycles the scenarios need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            results();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_fields();
        t_mono();
        t_trip();
        t_unmapped();
        results();
    end
endmodule : tb

// ===== rtl/anadbg_consts.svh
// register offsets, field positions and reset values of the analog debug bank
`ifndef ANADBG_CONSTS_SVH
`define ANADBG_CONSTS_SVH

// ****************************************************************
// register word indices; byte address is four times the index
// ****************************************************************
`define OFS_ANALOG_DEBUG_CONTROL_TWO   10'h03A
`define OFS_HEADPHONE_SHORT_DETECT     10'h03C
`define OFS_SHORT_MASK                 12'hFFC

// ****************************************************************
// analog debug control two fields
// ****************************************************************
`define BIT_LINE_OUT_SUPPLY_SELECT     14
`define BIT_SPARE_TO_ANALOG            13
`define BIT_DAC_LEFT_COPY_TO_RIGHT     12
`define BIT_PLL_OSCILLATOR_RETUNE      11
`define BIT_LINE_OUT_REFERENCE_TIE     10
`define BIT_DAC_SAMPLE_EDGE_FLIP       9
`define BIT_DAC_TRANSFER_EDGE_FLIP     8
`define BIT_DAC_ZERO_RETURN_EXTEND     7
`define BIT_DAC_AMP_CURRENT_DOUBLE     6
`define BIT_DAC_ZERO_RETURN_DISABLE    5
`define BIT_DAC_AMP_CLASS_A_FORCE      4
`define BIT_ADC_SAMPLE_EDGE_FLIP       3
`define BIT_ADC_TRANSFER_EDGE_FLIP     2
`define BIT_ADC_BIAS_REDUCE            1
`define BIT_ADC_DITHER_DISABLE         0
`define DEBUG_TWO_WRITE_MASK           16'h7FFF
`define DEBUG_TWO_RESET                16'h0000

// ****************************************************************
// headphone short detect fields
// ****************************************************************
`define RIGHT_TRIP_LSB                 12
`define RIGHT_TRIP_MSB                 14
`define RIGHT_TRIP_RESET               3'h0
`define SHORT_DETECT_WRITE_MASK        16'h7000

// ****************************************************************
// trip level codes in milliamps
// ****************************************************************
`define TRIP_STEP_MA                   8'h19
`define TRIP_BASE_MA                   8'h64

`endif

// ===== rtl/anadbg_pkg.sv
// types shared by the analog debug register bank
package anadbg_pkg;

    typedef enum logic [1:0]
    {
        RETUNE_IDLE  = 2'b00,
        RETUNE_ARMED = 2'b01,
        RETUNE_FIRE  = 2'b11
    } retune_state_t;

    typedef logic [15:0] reg_word_t;

endpackage : anadbg_pkg

// ===== rtl/analog_debug_regs.sv
// APB register bank for the analog debug word and the headphone short control word
//
// Overview of operation
// - bit 12 set copies the left DAC sample onto both channels.
// - bit 11 going high then low requests one PLL oscillator retune.
// - bit 14 picks line output supply: clear is io, set is analog.
// - bit 13 is a spare bit passed unchanged to the analog section.
// - bit 10 ties the main mid reference to the line output reference.
// - bit 9 flips the DAC output sampling clock edge.
// - bit 8 flips the clock edge of the DAC data transfer.
// - bit 7 lengthens the DAC return-to-zero interval.
// - bit 6 doubles DAC amplifier current while in class A.
// - bit 5 disables DAC return-to-zero operation.
// - bit 4 forces the DAC amplifier into class A.
// - bit 3 flips the ADC sampling clock edge.
// - bit 2 flips the clock edge of the ADC result transfer.
// - bit 1 cuts ADC bias currents by twenty percent.
// - bit 0 disables ADC dither injection.
// - short control bits 14:12 hold right trip level, reset zero; 15, 11 read zero.
// - trip codes 3,2,1,0 give 25..100 mA; 4..7 give 125..200 mA.
`timescale 1ns/100ps
`include "anadbg_consts.svh"

module analog_debug_regs
    import anadbg_pkg::*;
#(
    parameter int DATA_W = 16
)
(
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // dac path
    input  wire logic [23:0] DAC_LEFT_IN,
    input  wire logic [23:0] DAC_RIGHT_IN,
    output logic      [23:0] DAC_LEFT_OUT,
    output logic      [23:0] DAC_RIGHT_OUT,
    // analog and converter controls
    output logic             LINE_OUT_SUPPLY_SELECT,
    output logic             SPARE_TO_ANALOG,
    output logic             DAC_LEFT_COPY_TO_RIGHT,
    output logic             PLL_OSCILLATOR_RETUNE,
    output logic             LINE_OUT_REFERENCE_TIE,
    output logic             DAC_SAMPLE_EDGE_FLIP,
    output logic             DAC_TRANSFER_EDGE_FLIP,
    output logic             DAC_ZERO_RETURN_EXTEND,
    output logic             DAC_AMP_CURRENT_DOUBLE,
    output logic             DAC_ZERO_RETURN_DISABLE,
    output logic             DAC_AMP_CLASS_A_FORCE,
    output logic             ADC_SAMPLE_EDGE_FLIP,
    output logic             ADC_TRANSFER_EDGE_FLIP,
    output logic             ADC_BIAS_REDUCE,
    output logic             ADC_DITHER_DISABLE,
    // short detector
    output logic      [2:0]  RIGHT_SHORT_TRIP_LEVEL,
    output logic      [7:0]  RIGHT_SHORT_TRIP_MA
);

    // ****************************************************************
    // state
    // ****************************************************************
    reg_word_t     debug_two;
    reg_word_t     next_debug_two;
    logic [2:0]    right_trip;
    logic [2:0]    next_right_trip;
    retune_state_t retune_state;
    retune_state_t next_retune_state;
    logic [31:0]   rdata;
    logic [31:0]   next_rdata;
    logic [23:0]   dac_left;
    logic [23:0]   dac_right;
    logic [23:0]   next_dac_left;
    logic [23:0]   next_dac_right;
    logic          access;
    logic          wr;
    logic          hit_debug;
    logic          hit_short;
    logic [15:0]   lane_mask;

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic addr_is(input logic [11:0] a, input logic [9:0] idx);
        addr_is = (a[11:2] == idx);
    endfunction : addr_is

    // each 16-bit register owns one aligned word at four times its index,
    // data in the lower half so no two registers share a word
    always_comb
    begin
        access    = PSEL & PENABLE;
        wr        = access & PWRITE;
        hit_debug = addr_is(PADDR, `OFS_ANALOG_DEBUG_CONTROL_TWO);
        hit_short = addr_is(PADDR, `OFS_HEADPHONE_SHORT_DETECT);
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    always_comb
    begin
        next_debug_two = debug_two;
        next_right_trip = right_trip;
        lane_mask = 16'h0000;
        if (wr && hit_debug)
        begin
            lane_mask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}} & `DEBUG_TWO_WRITE_MASK;
            next_debug_two = (debug_two & ~lane_mask) | (PWDATA[15:0] & lane_mask);
        end
        if (wr && hit_short && PSTRB[1])
            next_right_trip = PWDATA[`RIGHT_TRIP_MSB:`RIGHT_TRIP_LSB];
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            debug_two  <= `DEBUG_TWO_RESET;
            right_trip <= `RIGHT_TRIP_RESET;
        end
        else
        begin
            debug_two  <= next_debug_two;
            right_trip <= next_right_trip;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    // reads return registered data one cycle after setup; pready stays high
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (PSEL && !PENABLE && !PWRITE)
        begin
            if (hit_debug)
                next_rdata[15:0] = debug_two & `DEBUG_TWO_WRITE_MASK;
            if (hit_short)
                next_rdata[15:0] = {1'b0, right_trip, 12'h000};
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            rdata <= 32'h0000_0000;
        else
            rdata <= next_rdata;
    end

    always_comb
    begin
        PRDATA  = rdata;
        PREADY  = 1'b1;
        PSLVERR = access & ~(hit_debug | hit_short);
    end

    // ****************************************************************
    // pll retune: high then low gives one pulse
    // ****************************************************************
    always_comb
    begin
        next_retune_state = retune_state;
        case (retune_state)
            RETUNE_IDLE:
                if (debug_two[`BIT_PLL_OSCILLATOR_RETUNE])
                    next_retune_state = RETUNE_ARMED;
            RETUNE_ARMED:
                if (!debug_two[`BIT_PLL_OSCILLATOR_RETUNE])
                    next_retune_state = RETUNE_FIRE;
            RETUNE_FIRE:
                next_retune_state = RETUNE_IDLE;
            default:
                next_retune_state = RETUNE_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            retune_state <= RETUNE_IDLE;
        else
            retune_state <= next_retune_state;
    end

    // ****************************************************************
    // dac mono copy
    // ****************************************************************
    // samples are registered so the copy switch cannot glitch mid-sample
    always_comb
    begin
        next_dac_left  = DAC_LEFT_IN;
        next_dac_right = debug_two[`BIT_DAC_LEFT_COPY_TO_RIGHT] ? DAC_LEFT_IN : DAC_RIGHT_IN;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            dac_left  <= 24'h00_0000;
            dac_right <= 24'h00_0000;
        end
        else
        begin
            dac_left  <= next_dac_left;
            dac_right <= next_dac_right;
        end
    end

    // ****************************************************************
    // static controls, dac sample outputs and the retune pulse
    // ****************************************************************
    always_comb
    begin
        DAC_LEFT_OUT            = dac_left;
        DAC_RIGHT_OUT           = dac_right;
        LINE_OUT_SUPPLY_SELECT  = debug_two[`BIT_LINE_OUT_SUPPLY_SELECT];
        SPARE_TO_ANALOG         = debug_two[`BIT_SPARE_TO_ANALOG];
        DAC_LEFT_COPY_TO_RIGHT  = debug_two[`BIT_DAC_LEFT_COPY_TO_RIGHT];
        PLL_OSCILLATOR_RETUNE   = (retune_state == RETUNE_FIRE);
        LINE_OUT_REFERENCE_TIE  = debug_two[`BIT_LINE_OUT_REFERENCE_TIE];
        DAC_SAMPLE_EDGE_FLIP    = debug_two[`BIT_DAC_SAMPLE_EDGE_FLIP];
        DAC_TRANSFER_EDGE_FLIP  = debug_two[`BIT_DAC_TRANSFER_EDGE_FLIP];
        DAC_ZERO_RETURN_EXTEND  = debug_two[`BIT_DAC_ZERO_RETURN_EXTEND];
        DAC_AMP_CURRENT_DOUBLE  = debug_two[`BIT_DAC_AMP_CURRENT_DOUBLE];
        DAC_ZERO_RETURN_DISABLE = debug_two[`BIT_DAC_ZERO_RETURN_DISABLE];
        DAC_AMP_CLASS_A_FORCE   = debug_two[`BIT_DAC_AMP_CLASS_A_FORCE];
        ADC_SAMPLE_EDGE_FLIP    = debug_two[`BIT_ADC_SAMPLE_EDGE_FLIP];
        ADC_TRANSFER_EDGE_FLIP  = debug_two[`BIT_ADC_TRANSFER_EDGE_FLIP];
        ADC_BIAS_REDUCE         = debug_two[`BIT_ADC_BIAS_REDUCE];
        ADC_DITHER_DISABLE      = debug_two[`BIT_ADC_DITHER_DISABLE];
        RIGHT_SHORT_TRIP_LEVEL  = right_trip;
    end

    // ****************************************************************
    // trip level decode
    // ****************************************************************
    trip_level_decode u_trip_decode
    (
        .code     (right_trip),
        .level_ma (RIGHT_SHORT_TRIP_MA)
    );

endmodule : analog_debug_regs

// ===== rtl/trip_level_decode.sv
// maps the 3-bit short trip code to its current in milliamps
`timescale 1ns/100ps
`include "anadbg_consts.svh"

module trip_level_decode
    import anadbg_pkg::*;
(
    // code in
    input  wire logic [2:0] code,
    // level out
    output logic      [7:0] level_ma
);

    // ****************************************************************
    // decode
    // ****************************************************************
    // codes 3..0 give 25..100 mA, codes 4..7 give 125..200 mA
    always_comb
    begin
        if (code[2])
            level_ma = 8'(`TRIP_BASE_MA + `TRIP_STEP_MA * ({6'h00, code[1:0]} + 8'h01));
        else
            level_ma = 8'(`TRIP_BASE_MA - `TRIP_STEP_MA * {6'h00, code[1:0]});
    end

endmodule : trip_level_decode
